// *** axis_zone_output_detector_test.sv ***
// self-checking bench for the zone output detector
`timescale 1ns/1ps
`include "axzod_map.svh"
module axis_zone_output_detector_test;
  localparam int NA = 2;
  localparam int DW = 40;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic ce = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [NA*32-1:0] axis_pos;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [15:0] o_port_out;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int pz [4] = '{1000, 2500, 3250, 4250};

  // 10 MHz clock
  always #50 i_core_clk = ~i_core_clk;

  axzod_axis_feed #(.NUM_AXES(NA)) feed (.i_core_clk(i_core_clk), .o_axis_pos(axis_pos));

  axzod_top #(.NUM_AXES(NA), .DWELL_CYCLES(DW)) dut (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ce(ce),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_axis_pos(axis_pos),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_port_out(o_port_out)
  );

  // counts a comparison and reports a mismatch at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // prints counts and verdict, then stops
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; read data checked on reads, error flag always
  task automatic xfer(input logic w, input int ax, input int slot, input logic [31:0] d,
                      input logic [31:0] exp, input logic eerr);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= 12'(ax * 512 + slot * 4);
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    @(posedge i_core_clk);
    while (o_pready !== 1'b1)
      @(posedge i_core_clk);
    if (!w)
      chk(o_prdata, exp);
    chk({31'h0000_0000, o_pslverr}, {31'h0000_0000, eerr});
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // hang guard
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      miscompares++;
      end_sim;
    end
  end

  // main sequence
  initial
  begin
    tick(6);
    i_srst <= 1'b0;
    chk({16'h0000, o_port_out}, 32'h0000_0000);
    xfer(0, 0, 86, 0, 32'h0000_0000, 0);
    xfer(0, 0, 0, 0, 32'h0000_0000, 0);
    // four zones on axis 0, each with its own port, read back
    for (int z = 0; z < 4; z++)
    begin
      xfer(1, 0, 86 + 3 * z, (z + 1) * 1000 + 500, 0, 0);
      xfer(1, 0, 87 + 3 * z, (z + 1) * 1000, 0, 0);
      xfer(1, 0, 88 + 3 * z, 301 + z, 0, 0);
    end
    for (int z = 0; z < 4; z++)
    begin
      xfer(0, 0, 86 + 3 * z, 0, (z + 1) * 1000 + 500, 0);
      xfer(0, 0, 87 + 3 * z, 0, (z + 1) * 1000, 0);
      xfer(0, 0, 88 + 3 * z, 0, 301 + z, 0);
    end
    // unmapped places answer with an error
    xfer(0, 0, 98, 0, 32'h0000_0000, 1);
    xfer(1, 0, 85, 32'h0000_1234, 0, 1);
    xfer(0, 2, 86, 0, 32'h0000_0000, 1);
    // visit each zone, bounds included, dwell then output
    for (int z = 0; z < 4; z++)
    begin
      feed.set_pos(0, pz[z]);
      tick(34);
      chk({16'h0000, o_port_out}, 32'h0000_0000);
      xfer(0, 0, 0, 0, 32'h0000_0010 << z, 0);
      tick(80);
      chk({16'h0000, o_port_out}, 32'h0000_0002 << z);
      xfer(0, 0, 0, 0, 32'h0000_0011 << z, 0);
    end
    // one step past the top bound is outside
    feed.set_pos(0, 4501);
    tick(40);
    chk({16'h0000, o_port_out}, 32'h0000_0000);
    // two short visits must not add up
    for (int k = 0; k < 2; k++)
    begin
      feed.set_pos(0, 1200);
      tick(30);
      chk({16'h0000, o_port_out}, 32'h0000_0000);
      feed.set_pos(0, 0);
      tick(40);
      chk({16'h0000, o_port_out}, 32'h0000_0000);
    end
    // two axes at once with distinct ports
    xfer(1, 0, 86, 200000, 0, 0);
    xfer(1, 0, 87, 150000, 0, 0);
    xfer(1, 0, 88, 311, 0, 0);
    xfer(1, 1, 86, 125000, 0, 0);
    xfer(1, 1, 87, 75000, 0, 0);
    xfer(1, 1, 88, 312, 0, 0);
    feed.set_pos(0, 175000);
    feed.set_pos(1, 100000);
    tick(120);
    chk({16'h0000, o_port_out}, 32'h0000_1800);
    // clock enable low freezes scan, timers and outputs
    @(posedge i_core_clk);
    ce <= 1'b0;
    feed.set_pos(0, 0);
    tick(40);
    chk({16'h0000, o_port_out}, 32'h0000_1800);
    ce <= 1'b1;
    tick(40);
    chk({16'h0000, o_port_out}, 32'h0000_1000);
    xfer(0, 1, 0, 0, 32'h0000_0011, 0);
    end_sim;
  end
endmodule

// *** axzod_axis_feed.sv ***
// axis position feedback model driving the zone detector positions
`timescale 1ns/1ps
module axzod_axis_feed #(
  parameter int NUM_AXES = 2
)(
  input wire logic i_core_clk,
  output logic [NUM_AXES*32-1:0] o_axis_pos
);
  // per-axis position in signed 0.001 mm steps, parked at -1, one step below the cleared zone windows
  logic signed [31:0] pos [NUM_AXES];
  initial
  begin
    for (int a = 0; a < NUM_AXES; a++)
      pos[a] = 32'hFFFF_FFFF;
  end
  // a move lands just after a rising edge, as an encoder latch would
  task automatic set_pos(input int ax, input logic signed [31:0] p);
    @(posedge i_core_clk);
    pos[ax] <= p;
  endtask
  // pack positions onto the feedback bus
  always_comb
  begin
    for (int a = 0; a < NUM_AXES; a++)
      o_axis_pos[a*32 +: 32] = pos[a];
  end
endmodule

// *** axzod_map.svh ***
// register slots, field positions and timing constants of the zone detector
`ifndef AXZOD_MAP_SVH
`define AXZOD_MAP_SVH

// per-axis setting slots, printed slot index = byte address / 4
`define AXZOD_SLOT_FIRST 7'h56
`define AXZOD_SLOT_LAST 7'h61
`define AXZOD_SLOT_STATUS 7'h00
`define AXZOD_SLOTS_PER_AXIS 12
`define AXZOD_SLOTS_PER_ZONE 3
`define AXZOD_ZONES_PER_AXIS 4
`define AXZOD_OFS_MAX 0
`define AXZOD_OFS_MIN 1
`define AXZOD_OFS_PORT 2

// address fields: word slot in [8:2], axis bank above
`define AXZOD_SLOT_LSB 2
`define AXZOD_SLOT_MSB 8
`define AXZOD_AXIS_LSB 9

// field widths and reset values
`define AXZOD_DATA_W 32
`define AXZOD_PORT_W 16
`define AXZOD_CNT_W 16
`define AXZOD_WORD_RST 32'h0000_0000

// dwell time in microseconds, clock rate in MHz
`define AXZOD_DWELL_US 3000
`define AXZOD_CLK_MHZ 10

`endif

// *** axzod_param_mem.sv ***
// zone settings memory: one write port, two registered read ports
`timescale 1ns/1ps
`include "axzod_map.svh"
module axzod_param_mem #(
  parameter int DEPTH = 24,
  parameter int AW = 5
)(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [`AXZOD_DATA_W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr_a,
  output logic [`AXZOD_DATA_W-1:0] o_rdata_a,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [`AXZOD_DATA_W-1:0] o_rdata_b
);
  logic [`AXZOD_DATA_W-1:0] mem [DEPTH];

  generate
    if (DEPTH < 1 || DEPTH > (1 << AW))
    begin : g_bad_depth
      $error("axzod_param_mem: depth does not fit address width");
    end
  endgenerate

  // storage, cleared at reset so every zone starts unassigned
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= `AXZOD_WORD_RST;
    end
    else if (i_ce && i_we)
      mem[i_waddr] <= i_wdata;
  end

  // registered read ports, bus side and scan side
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_rdata_a <= `AXZOD_WORD_RST;
      o_rdata_b <= `AXZOD_WORD_RST;
    end
    else if (i_ce)
    begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end
endmodule

// *** axzod_pkg.sv ***
// types shared by the zone detector files
package axzod_pkg;
  // one-hot scan sequencer states
  typedef enum logic [3:0]
  {
    AXZOD_RD_MAX = 4'h1,
    AXZOD_RD_MIN = 4'h2,
    AXZOD_RD_PORT = 4'h4,
    AXZOD_EVAL = 4'h8
  } axzod_scan_e;

  // position in 0.001 mm units, two's complement
  typedef logic signed [31:0] axzod_pos_t;
endpackage

// *** axzod_top.sv ***
// per-axis zone output detector with apb settings access
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "axzod_map.svh"
module axzod_top #(
  parameter int NUM_AXES = 2,
  parameter int NUM_PORTS = 16,
  parameter int PORT_BASE = 300,
  parameter int ADDR_W = 12,
  parameter int DWELL_CYCLES = `AXZOD_DWELL_US * `AXZOD_CLK_MHZ
)(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [`AXZOD_DATA_W-1:0] i_pwdata,
  input wire logic [NUM_AXES*`AXZOD_DATA_W-1:0] i_axis_pos,
  output logic [`AXZOD_DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [NUM_PORTS-1:0] o_port_out
);
  localparam int ZPA = `AXZOD_ZONES_PER_AXIS;
  localparam int NZ = NUM_AXES * ZPA;
  localparam int MEM_DEPTH = NUM_AXES * `AXZOD_SLOTS_PER_AXIS;
  localparam int MEM_AW = $clog2(MEM_DEPTH);
  localparam int ZI_W = $clog2(NZ);
  localparam int AX_W = ADDR_W - `AXZOD_AXIS_LSB;
  localparam int PW = `AXZOD_PORT_W;
  localparam logic [ZI_W-1:0] LAST_ZONE = ZI_W'(NZ - 1);

  // parameters the structure cannot serve
  generate
    if (NUM_AXES < 1 || AX_W < 1 || NUM_AXES > (1 << AX_W) || NUM_PORTS < 1
        || PORT_BASE < 1 || PORT_BASE + NUM_PORTS > (1 << PW)
        || DWELL_CYCLES < 1 || DWELL_CYCLES >= (1 << `AXZOD_CNT_W))
    begin : g_bad_param
      $error("axzod_top: unsupported parameter value");
    end
  endgenerate

  // setting word index of an axis slot offset, shared by bus and scan
  function automatic logic [MEM_AW-1:0] cfg_index(input int axis, input int ofs);
    cfg_index = MEM_AW'(axis * `AXZOD_SLOTS_PER_AXIS + ofs);
  endfunction

  // ---- bus decode ----
  logic [6:0] slot;
  logic [AX_W-1:0] axis;
  logic axis_ok;
  logic cfg_hit;
  logic stat_hit;
  logic [MEM_AW-1:0] apb_idx;
  logic apb_done;
  logic mem_we;
  logic rd_stage;

  // word slot and axis bank of the current bus address
  assign slot = i_paddr[`AXZOD_SLOT_MSB:`AXZOD_SLOT_LSB];
  assign axis = i_paddr[ADDR_W-1:`AXZOD_AXIS_LSB];
  assign axis_ok = int'(axis) < NUM_AXES;
  assign cfg_hit = axis_ok && slot >= `AXZOD_SLOT_FIRST && slot <= `AXZOD_SLOT_LAST;
  assign stat_hit = axis_ok && slot == `AXZOD_SLOT_STATUS;
  assign apb_idx = cfg_index(int'(axis), int'(slot - `AXZOD_SLOT_FIRST));

  // completing edge of a transfer; writes land exactly there
  assign apb_done = i_psel && i_penable && o_pready;
  assign mem_we = apb_done && i_pwrite && cfg_hit;

  // ---- scan sequencer ----
  axzod_pkg::axzod_scan_e scan_state;
  logic [ZI_W-1:0] scan_idx;
  logic [MEM_AW-1:0] scan_addr;
  logic [`AXZOD_DATA_W-1:0] cap_max;
  logic [`AXZOD_DATA_W-1:0] cap_min;
  logic [`AXZOD_DATA_W-1:0] rd_a;
  logic [`AXZOD_DATA_W-1:0] rd_b;
  axzod_pkg::axzod_pos_t scan_pos;
  logic scan_inside;
  logic zone_load;

  // zone settings, read by the bus on port a and the scan on port b
  axzod_param_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_waddr(apb_idx),
    .i_wdata(i_pwdata),
    .i_raddr_a(apb_idx),
    .o_rdata_a(rd_a),
    .i_raddr_b(scan_addr),
    .o_rdata_b(rd_b)
  );

  // scan address: zone n of an axis owns three consecutive slots
  always_comb
  begin
    int zofs;
    zofs = int'(scan_idx[1:0]) * `AXZOD_SLOTS_PER_ZONE;
    unique case (scan_state)
      axzod_pkg::AXZOD_RD_MAX:
        scan_addr = cfg_index(int'(scan_idx) / ZPA, zofs + `AXZOD_OFS_MAX);
      axzod_pkg::AXZOD_RD_MIN:
        scan_addr = cfg_index(int'(scan_idx) / ZPA, zofs + `AXZOD_OFS_MIN);
      axzod_pkg::AXZOD_RD_PORT, axzod_pkg::AXZOD_EVAL:
        scan_addr = cfg_index(int'(scan_idx) / ZPA, zofs + `AXZOD_OFS_PORT);
      default:
        scan_addr = '0;
    endcase
  end

  // walk every zone of every axis: max, min, port, then evaluate
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      scan_state <= axzod_pkg::AXZOD_RD_MAX;
      scan_idx <= '0;
    end
    else if (i_ce)
    begin
      unique case (scan_state)
        axzod_pkg::AXZOD_RD_MAX:
          scan_state <= axzod_pkg::AXZOD_RD_MIN;
        axzod_pkg::AXZOD_RD_MIN:
          scan_state <= axzod_pkg::AXZOD_RD_PORT;
        axzod_pkg::AXZOD_RD_PORT:
          scan_state <= axzod_pkg::AXZOD_EVAL;
        axzod_pkg::AXZOD_EVAL:
        begin
          scan_state <= axzod_pkg::AXZOD_RD_MAX;
          scan_idx <= (scan_idx == LAST_ZONE) ? '0 : scan_idx + 1'b1;
        end
        default:
          scan_state <= axzod_pkg::AXZOD_RD_MAX;
      endcase
    end
  end

  // capture the bounds as they come out of the memory
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      cap_max <= `AXZOD_WORD_RST;
      cap_min <= `AXZOD_WORD_RST;
    end
    else if (i_ce)
    begin
      if (scan_state == axzod_pkg::AXZOD_RD_MIN)
        cap_max <= rd_b;
      if (scan_state == axzod_pkg::AXZOD_RD_PORT)
        cap_min <= rd_b;
    end
  end

  // inclusive window test, position and bounds both in 0.001 mm
  assign scan_pos = i_axis_pos[(int'(scan_idx) / ZPA) * `AXZOD_DATA_W +: `AXZOD_DATA_W];
  assign scan_inside = (scan_pos <= $signed(cap_max)) && (scan_pos >= $signed(cap_min));
  assign zone_load = scan_state == axzod_pkg::AXZOD_EVAL;

  // ---- zones ----
  logic [NZ-1:0] zone_act;
  logic [NZ-1:0] zone_in;
  logic [PW-1:0] zone_port [NZ];

  // one dwell timer per zone, four per axis
  generate
    for (genvar z = 0; z < NZ; z++)
    begin : g_zone
      axzod_zone_unit #(
        .CNT_W(`AXZOD_CNT_W),
        .DWELL(DWELL_CYCLES)
      ) u_zone (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_load(zone_load && scan_idx == ZI_W'(z)),
        .i_inside(scan_inside),
        .i_port(rd_b[PW-1:0]),
        .o_port(zone_port[z]),
        .o_inside(zone_in[z]),
        .o_active(zone_act[z])
      );
    end
  endgenerate

  // ---- output ports ----
  logic [NUM_PORTS-1:0] next_port_out;

  // a port is on while any dwelled zone names it; unique numbers assumed
  generate
    for (genvar b = 0; b < NUM_PORTS; b++)
    begin : g_port
      always_comb
      begin
        next_port_out[b] = 1'b0;
        for (int z = 0; z < NZ; z++)
          if (zone_act[z] && zone_port[z] == PW'(PORT_BASE + b))
            next_port_out[b] = 1'b1;
      end
    end
  endgenerate

  // registered port drive, off again as soon as no zone holds it
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_port_out <= '0;
    else if (i_ce)
      o_port_out <= next_port_out;
  end

  // ---- bus answer ----
  logic [`AXZOD_DATA_W-1:0] status_word;

  // per-axis status: dwelled zones in [3:0], inside flags in [7:4]
  always_comb
  begin
    status_word = '0;
    if (axis_ok)
    begin
      status_word[ZPA-1:0] = zone_act[int'(axis) * ZPA +: ZPA];
      status_word[2*ZPA-1:ZPA] = zone_in[int'(axis) * ZPA +: ZPA];
    end
  end

  // two wait cycles: address to memory, then registered answer
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      rd_stage <= 1'b0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end
    else if (i_ce)
    begin
      if (apb_done)
      begin
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
      end
      else if (i_psel && i_penable && !rd_stage)
        rd_stage <= 1'b1;
      else if (rd_stage)
      begin
        rd_stage <= 1'b0;
        o_pready <= 1'b1;
        o_pslverr <= !(cfg_hit || stat_hit);
        if (!i_pwrite && cfg_hit)
          o_prdata <= rd_a;
        else if (!i_pwrite && stat_hit)
          o_prdata <= status_word;
        else
          o_prdata <= '0;
      end
    end
  end

  // ---- checks ----
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_scan_zone_wrap:
    assert property ((i_ce && zone_load && scan_idx == LAST_ZONE) |=> scan_idx == '0)
      else $error("scan did not wrap after the last zone");
  a_scan_zone_step:
    assert property ((i_ce && scan_state == axzod_pkg::AXZOD_RD_MAX)
      |=> scan_state == axzod_pkg::AXZOD_RD_MIN
      ##1 (scan_state == axzod_pkg::AXZOD_RD_PORT || !$past(i_ce)))
      else $error("scan left its max, min, port order");
  a_zone_one_slot:
    assert property ((mem_we && int'(axis) == 0 && slot == 7'h58) |-> apb_idx == MEM_AW'(2))
      else $error("zone one port slot mapped wrongly");
  a_zone_three_slot:
    assert property ((mem_we && int'(axis) == 0 && slot == 7'h5C) |-> apb_idx == MEM_AW'(6))
      else $error("zone three slot mapped wrongly");
  a_zone_four_slot:
    assert property ((mem_we && int'(axis) == 0 && slot == 7'h61) |-> apb_idx == MEM_AW'(11))
      else $error("zone four slot mapped wrongly");
  a_bound_above_max:
    assert property ((zone_load && scan_pos > $signed(cap_max)) |-> !scan_inside)
      else $error("position above max counted inside");
  a_port_has_zone:
    assert property ((o_port_out != '0) |-> $past(|zone_act))
      else $error("output on with no dwelled zone");
  a_port_clears_out:
    assert property ((i_ce && zone_act == '0) |=> o_port_out == '0)
      else $error("output kept after all zones dropped");
  a_bus_answer_time:
    assert property ((($rose(i_psel && i_penable) && i_ce) ##1 i_ce) |-> ##1 o_pready)
      else $error("bus answer not on the second edge");
  a_ce_holds_ports:
    assert property (!i_ce |=> $stable(o_port_out))
      else $error("output ports moved while clock enable was low");
endmodule

// *** axzod_zone_unit.sv ***
// one zone: sampled inside flag, dwell timer and output request
`timescale 1ns/1ps
`include "axzod_map.svh"
module axzod_zone_unit #(
  parameter int CNT_W = `AXZOD_CNT_W,
  parameter int DWELL = 30000
)(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic i_inside,
  input wire logic [`AXZOD_PORT_W-1:0] i_port,
  output logic [`AXZOD_PORT_W-1:0] o_port,
  output logic o_inside,
  output logic o_active
);
  localparam logic [CNT_W-1:0] DWELL_C = CNT_W'(DWELL);
  localparam logic [CNT_W-1:0] DWELL_M1 = CNT_W'(DWELL - 1);

  logic [CNT_W-1:0] cnt;
  logic leave;

  assign leave = i_load && !i_inside;

  // sampled membership and assigned port, refreshed once per scan
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_inside <= 1'b0;
      o_port <= '0;
    end
    else if (i_ce && i_load)
    begin
      o_inside <= i_inside;
      o_port <= i_port;
    end
  end

  // dwell timer, restarted whenever the axis is found outside
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      cnt <= '0;
    else if (i_ce)
    begin
      if (leave || !o_inside)
        cnt <= '0;
      else if (cnt != DWELL_C)
        cnt <= cnt + 1'b1;
    end
  end

  // output only after an unbroken dwell, dropped at once on leaving
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_active <= 1'b0;
    else if (i_ce)
    begin
      if (leave)
        o_active <= 1'b0;
      else
        o_active <= o_inside && (cnt >= DWELL_M1);
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_dwell_rise_time:
    assert property ($rose(o_active) |-> $past(o_inside) && $past(cnt) == DWELL_M1)
      else $error("zone output rose without a full dwell");
  a_short_visit_quiet:
    assert property ((i_ce && !leave && cnt < DWELL_M1 && !o_active) |=> !o_active)
      else $error("zone output rose before the dwell ended");
  a_leave_drops_out:
    assert property ((i_ce && leave) |=> !o_active && cnt == '0 ##1 !o_active)
      else $error("zone output or timer kept after leaving");
endmodule
